// >>> src/asc_pkg.sv
// Constants and types for the slot front-end configuration bank.
// Assumes a 10 MHz register clock and APB word access.
package asc_pkg;
  localparam int ADDR_W = 12;
  localparam int REG_W  = 16;

  // Register indexes; the byte address is four times the index
  localparam logic [7:0] IDX_ORDER_A = 8'h17;
  localparam logic [7:0] IDX_ORDER_B = 8'h1D;
  localparam logic [7:0] IDX_WIN_A   = 8'h39;
  localparam logic [7:0] IDX_WIN_B   = 8'h3B;
  localparam logic [7:0] IDX_AMP_A   = 8'h42;
  localparam logic [7:0] IDX_ROUTE_A = 8'h43;
  localparam logic [7:0] IDX_CH_GAIN = 8'h55;
  localparam logic [7:0] IDX_STATUS  = 8'h60;

  localparam logic [15:0] RST_ORDER   = 16'h0000;
  localparam logic [15:0] RST_WIN_A   = 16'h22FC;
  localparam logic [15:0] RST_WIN_B   = 16'h2017;
  localparam logic [15:0] RST_AMP_A   = 16'h1C38;
  localparam logic [15:0] RST_ROUTE_A = 16'hADA5;
  localparam logic [15:0] RST_CH_GAIN = 16'h0000;

  localparam int ORDER_LSB  = 0;
  localparam int WIDTH_LSB  = 11;
  localparam int OFFSET_LSB = 0;
  localparam int BUF_BIT    = 7;
  localparam int IND_BIT    = 6;
  localparam int VREF_LSB   = 4;
  localparam int GAIN_LSB   = 0;

  localparam logic [15:0] ROUTE_FULL       = 16'hADA5;
  localparam logic [15:0] ROUTE_TIA_BUF    = 16'hAE65;
  localparam logic [15:0] ROUTE_TIA_DIRECT = 16'hB065;

  // Window step sizes in picoseconds and the clock period
  localparam int CLK_PERIOD_PS  = 100000;
  localparam int WIDTH_STEP_PS  = 1000000;
  localparam int OFFSET_STEP_PS = 31250;
  localparam int WIDTH_STEP_CYC = WIDTH_STEP_PS / CLK_PERIOD_PS;

  typedef enum logic [3:0] {
    PATH_FULL       = 4'b0001,
    PATH_TIA_BUF    = 4'b0010,
    PATH_TIA_DIRECT = 4'b0100,
    PATH_RESERVED   = 4'b1000
  } asc_path_t;

  function automatic asc_path_t decode_path(input logic [15:0] word);
    if (word == ROUTE_FULL) return PATH_FULL;
    if (word == ROUTE_TIA_BUF) return PATH_TIA_BUF;
    if (word == ROUTE_TIA_DIRECT) return PATH_TIA_DIRECT;
    return PATH_RESERVED;
  endfunction

  // Least delay, so the offset rounds up to whole cycles
  function automatic logic [15:0] offset_cycles(input logic [10:0] units);
    int ps;
    ps = int'(units) * OFFSET_STEP_PS;
    return 16'((ps + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  endfunction
endpackage

// >>> src/asc_polarity_seq.sv
// Per-pulse integration polarity for one time slot.
// Assumes frame_start precedes the first pulse of each sample.
`timescale 1ns/100ps
module asc_polarity_seq (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       frame_start,
  input  wire logic       pulse,
  input  wire logic [3:0] order,
  output logic            reversed,
  output logic [1:0]      pulse_index
);
  logic [1:0] idx_reg;
  logic       rev_reg;

  // Counter wraps after four pulses, so the pattern repeats
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      idx_reg <= 2'h0;
      rev_reg <= 1'b0;
    end else if (frame_start) begin
      idx_reg <= 2'h0;
    end else if (pulse) begin
      rev_reg <= order[idx_reg];
      idx_reg <= idx_reg + 2'h1;
    end
  end

  assign reversed    = rev_reg;
  assign pulse_index = idx_reg;
endmodule

// >>> src/asc_slot_config.sv
// Slot A and slot B front-end configuration bank behind APB.
// Assumes APB3 without wait states and synchronous slot strobes.
`timescale 1ns/100ps

// How it works
// - Buffer bit turns slot A integrator into buffer
// - Per-channel enable takes gains from two registers
// - Reference code selects one of four voltages
// - Shared gain code drives all four channels, lowest only with per-channel enable
// - Routing word 0xADA5 selects full analog path
// - Routing 0xB065 is unbuffered amplifier-to-converter mode
// - Order bit n sets polarity of pulse n+1
// - Zero is normal, one reversed integration
// - Slot B window width in microsecond steps
// - Slot B window offset in 31.25 ns steps
// - Slot A window uses same units
// - Slot A order field mirrors slot B
module asc_slot_config (
  input  wire logic                      clk,
  input  wire logic                      rst_n,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [asc_pkg::ADDR_W-1:0] paddr,
  input  wire logic [31:0]               pwdata,
  output logic      [31:0]               prdata,
  output logic                           pready,
  output logic                           pslverr,
  input  wire logic                      sampling_active,
  input  wire logic                      slot_a_start,
  input  wire logic                      slot_b_start,
  input  wire logic                      slot_a_pulse,
  input  wire logic                      slot_b_pulse,
  output logic      [7:0]                slot_a_ch_gain,
  output logic      [1:0]                slot_a_amp_reference_select,
  output logic                           slot_a_integrator_buffer_mode,
  output asc_pkg::asc_path_t             slot_a_path_mode,
  output logic                           slot_a_window,
  output logic                           slot_b_window,
  output logic                           slot_a_reversed,
  output logic                           slot_b_reversed
);
  import asc_pkg::*;

  logic [15:0] order_a_reg;
  logic [15:0] order_b_reg;
  logic [15:0] win_a_reg;
  logic [15:0] win_b_reg;
  logic [15:0] amp_a_reg;
  logic [15:0] route_a_reg;
  logic [15:0] ch_gain_reg;

  // Copies seen by the front end
  logic [7:0]  gain_reg;
  logic [1:0]  vref_reg;
  logic        buf_reg;
  asc_path_t   path_reg;
  logic [3:0]  ord_a_reg;
  logic [3:0]  ord_b_reg;
  logic [15:0] app_win_a_reg;
  logic [15:0] app_win_b_reg;

  logic [15:0] rd16;
  logic        busy_a;
  logic        busy_b;

  // Bus decode
  wire [7:0] idx     = paddr[9:2];
  wire       hi_zero = (paddr[ADDR_W-1:10] == '0);
  wire       access  = psel & penable;
  wire       wr_en   = access & pwrite;

  wire hit_ord_a = hi_zero & (idx == IDX_ORDER_A);
  wire hit_ord_b = hi_zero & (idx == IDX_ORDER_B);
  wire hit_win_a = hi_zero & (idx == IDX_WIN_A);
  wire hit_win_b = hi_zero & (idx == IDX_WIN_B);
  wire hit_amp_a = hi_zero & (idx == IDX_AMP_A);
  wire hit_route = hi_zero & (idx == IDX_ROUTE_A);
  wire hit_chg   = hi_zero & (idx == IDX_CH_GAIN);
  wire hit_stat  = hi_zero & (idx == IDX_STATUS);

  wire mapped = hit_ord_a | hit_ord_b | hit_win_a | hit_win_b |
                hit_amp_a | hit_route | hit_chg | hit_stat;

  assign pready  = 1'b1;
  assign pslverr = access & ~mapped;

  // Per-register write strobes; status is read only and ignores writes
  wire        we_ord_a = wr_en & hit_ord_a;
  wire        we_ord_b = wr_en & hit_ord_b;
  wire        we_win_a = wr_en & hit_win_a;
  wire        we_win_b = wr_en & hit_win_b;
  wire        we_amp_a = wr_en & hit_amp_a;
  wire        we_route = wr_en & hit_route;
  wire        we_chg   = wr_en & hit_chg;
  wire [15:0] wr16     = pwdata[15:0];

  // One short process per stored register
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      order_a_reg <= RST_ORDER;
    end else if (we_ord_a) begin
      order_a_reg <= wr16;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      order_b_reg <= RST_ORDER;
    end else if (we_ord_b) begin
      order_b_reg <= wr16;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      win_a_reg <= RST_WIN_A;
    end else if (we_win_a) begin
      win_a_reg <= wr16;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      win_b_reg <= RST_WIN_B;
    end else if (we_win_b) begin
      win_b_reg <= wr16;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      amp_a_reg <= RST_AMP_A;
    end else if (we_amp_a) begin
      amp_a_reg <= wr16;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      route_a_reg <= RST_ROUTE_A;
    end else if (we_route) begin
      route_a_reg <= wr16;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ch_gain_reg <= RST_CH_GAIN;
    end else if (we_chg) begin
      ch_gain_reg <= wr16;
    end
  end

  // Field decode of the live registers
  wire       buf_bit = amp_a_reg[BUF_BIT];
  wire       ind_en  = amp_a_reg[IND_BIT];
  wire [1:0] g_all   = amp_a_reg[GAIN_LSB +: 2];
  wire [1:0] vref    = amp_a_reg[VREF_LSB +: 2];

  // Codes 0..3 mean 200, 100, 50 and 25 kilohm per channel
  wire [7:0] gain_next = ind_en ? {ch_gain_reg[5:0], g_all}
                                : {4{g_all}};

  asc_path_t path_live;
  assign path_live = decode_path(route_a_reg);

  // Flags a routing word whose buffer setting disagrees with it;
  // the host owns this pairing, so the bank only reports it
  wire buf_mismatch =
    ((path_live == PATH_TIA_BUF) & ~buf_bit) |
    ((path_live == PATH_TIA_DIRECT) & buf_bit) |
    ((path_live == PATH_FULL) & buf_bit);

  // Settings reach the front end only between measurements, so a
  // sample never mixes old and new values; a write during sampling
  // is stored and applied once sampling stops
  wire apply = ~sampling_active;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      gain_reg <= {4{RST_AMP_A[GAIN_LSB +: 2]}};
    end else if (apply) begin
      gain_reg <= gain_next;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      vref_reg <= RST_AMP_A[VREF_LSB +: 2];
    end else if (apply) begin
      vref_reg <= vref;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      buf_reg <= RST_AMP_A[BUF_BIT];
    end else if (apply) begin
      buf_reg <= buf_bit;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      path_reg <= PATH_FULL;
    end else if (apply) begin
      path_reg <= path_live;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ord_a_reg <= RST_ORDER[ORDER_LSB +: 4];
    end else if (apply) begin
      ord_a_reg <= order_a_reg[ORDER_LSB +: 4];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ord_b_reg <= RST_ORDER[ORDER_LSB +: 4];
    end else if (apply) begin
      ord_b_reg <= order_b_reg[ORDER_LSB +: 4];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      app_win_a_reg <= RST_WIN_A;
    end else if (apply) begin
      app_win_a_reg <= win_a_reg;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      app_win_b_reg <= RST_WIN_B;
    end else if (apply) begin
      app_win_b_reg <= win_b_reg;
    end
  end

  // Reference codes 0..3 mean 1.14, 1.01, 0.90 and 1.27 V
  assign slot_a_amp_reference_select   = vref_reg;
  assign slot_a_ch_gain                = gain_reg;
  assign slot_a_integrator_buffer_mode = buf_reg;
  assign slot_a_path_mode              = path_reg;

  // Read mux; reserved bits read back as written
  always_comb begin
    rd16 = 16'h0000;
    unique case (1'b1)
      hit_ord_a: rd16 = order_a_reg;
      hit_ord_b: rd16 = order_b_reg;
      hit_win_a: rd16 = win_a_reg;
      hit_win_b: rd16 = win_b_reg;
      hit_amp_a: rd16 = amp_a_reg;
      hit_route: rd16 = route_a_reg;
      hit_chg:   rd16 = ch_gain_reg;
      hit_stat:  rd16 = {8'h00, busy_b, busy_a, sampling_active,
                         buf_mismatch, path_live};
      default:   rd16 = 16'h0000;
    endcase
  end

  assign prdata = {16'h0000, rd16};

  // Window timing per slot
  asc_window_timer u_win_a (
    .clk          (clk),
    .rst_n        (rst_n),
    .start        (slot_a_start),
    .width_units  (app_win_a_reg[WIDTH_LSB +: 5]),
    .offset_units (app_win_a_reg[OFFSET_LSB +: 11]),
    .window_open  (slot_a_window),
    .busy         (busy_a)
  );

  asc_window_timer u_win_b (
    .clk          (clk),
    .rst_n        (rst_n),
    .start        (slot_b_start),
    .width_units  (app_win_b_reg[WIDTH_LSB +: 5]),
    .offset_units (app_win_b_reg[OFFSET_LSB +: 11]),
    .window_open  (slot_b_window),
    .busy         (busy_b)
  );

  // Pulse polarity per slot
  asc_polarity_seq u_pol_a (
    .clk         (clk),
    .rst_n       (rst_n),
    .frame_start (slot_a_start),
    .pulse       (slot_a_pulse),
    .order       (ord_a_reg),
    .reversed    (slot_a_reversed),
    .pulse_index ()
  );

  asc_polarity_seq u_pol_b (
    .clk         (clk),
    .rst_n       (rst_n),
    .frame_start (slot_b_start),
    .pulse       (slot_b_pulse),
    .order       (ord_b_reg),
    .reversed    (slot_b_reversed),
    .pulse_index ()
  );
endmodule

// >>> src/asc_window_timer.sv
// Integration window timer for one time slot.
// Assumes start is a one-cycle pulse from the slot timing logic.
`timescale 1ns/100ps
module asc_window_timer
  import asc_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        start,
  input  wire logic [4:0]  width_units,
  input  wire logic [10:0] offset_units,
  output logic             window_open,
  output logic             busy
);
  typedef enum logic [2:0] {
    W_IDLE  = 3'b001,
    W_DELAY = 3'b010,
    W_OPEN  = 3'b100
  } asc_win_t;

  asc_win_t    state_reg, state_next;
  logic [15:0] cnt_reg, cnt_next;
  wire  [15:0] off_cyc = offset_cycles(offset_units);
  wire  [15:0] wid_cyc = 16'(int'(width_units) * WIDTH_STEP_CYC);

  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg - 16'h0001;
    unique case (state_reg)
      W_IDLE: begin
        cnt_next = off_cyc;
        if (start && wid_cyc != 16'h0000) begin
          state_next = (off_cyc == 16'h0000) ? W_OPEN : W_DELAY;
          if (off_cyc == 16'h0000) cnt_next = wid_cyc;
        end
      end
      W_DELAY: begin
        if (cnt_reg == 16'h0001) begin
          state_next = W_OPEN;
          cnt_next   = wid_cyc;
        end
      end
      W_OPEN: begin
        if (cnt_reg == 16'h0001) state_next = W_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_reg <= W_IDLE;
      cnt_reg   <= 16'h0000;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
    end
  end

  assign window_open = (state_reg == W_OPEN);
  assign busy        = (state_reg != W_IDLE);
endmodule

// >>> verification/asc_slot_config_monitor.sv
// Checker for the slot bank: reset outputs, frozen outputs, polarity and window length.
// Bound into asc_slot_config and sees only its ports.
`timescale 1ns/100ps
module asc_slot_config_monitor (
  input wire logic               clk,
  input wire logic               rst_n,
  input wire logic               psel,
  input wire logic               penable,
  input wire logic               pready,
  input wire logic               sampling_active,
  input wire logic               slot_a_pulse,
  input wire logic               slot_b_pulse,
  input wire logic [7:0]         slot_a_ch_gain,
  input wire logic [1:0]         slot_a_amp_reference_select,
  input wire asc_pkg::asc_path_t slot_a_path_mode,
  input wire logic               slot_b_window,
  input wire logic               slot_a_reversed,
  input wire logic               slot_b_reversed
);
  import asc_pkg::*;
  logic [15:0] b_len_reg;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Counts high cycles of the slot B window; cleared while low
  always_ff @(posedge clk) begin
    b_len_reg <= (rst_n && slot_b_window) ? b_len_reg + 16'h0001 : 16'h0000;
  end
  sequence s_access;
    psel && penable;
  endsequence
  property p_ready;     s_access |-> pready; endproperty
  property p_rst_out;   $rose(rst_n) |-> slot_a_path_mode == PATH_FULL
                          && slot_a_amp_reference_select == 2'b11; endproperty
  property p_onehot;    $onehot(slot_a_path_mode); endproperty
  property p_hold_path; sampling_active |=> $stable(slot_a_path_mode); endproperty
  property p_hold_amp;  sampling_active |=> $stable(slot_a_ch_gain)
                          && $stable(slot_a_amp_reference_select); endproperty
  property p_rev_a;     $changed(slot_a_reversed) |-> $past(slot_a_pulse); endproperty
  property p_rev_b;     $changed(slot_b_reversed) |-> $past(slot_b_pulse); endproperty
  property p_width_b;   $fell(slot_b_window) |-> b_len_reg != 16'h0000
                          && b_len_reg % WIDTH_STEP_CYC == 0; endproperty
  a_ready: assert property (p_ready) else $error("pready low in access");
  a_rst_out: assert property (p_rst_out) else $error("bad reset outputs");
  a_onehot: assert property (p_onehot) else $error("path not one-hot");
  a_hold_path: assert property (p_hold_path) else $error("path moved");
  a_hold_amp: assert property (p_hold_amp) else $error("gain moved");
  a_rev_a: assert property (p_rev_a) else $error("slot a polarity moved");
  a_rev_b: assert property (p_rev_b) else $error("slot b polarity moved");
  a_width_b: assert property (p_width_b) else $error("slot b window length");
endmodule
bind asc_slot_config asc_slot_config_monitor u_mon (
  .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pready(pready),
  .sampling_active(sampling_active), .slot_a_pulse(slot_a_pulse),
  .slot_b_pulse(slot_b_pulse), .slot_a_ch_gain(slot_a_ch_gain),
  .slot_a_amp_reference_select(slot_a_amp_reference_select),
  .slot_a_path_mode(slot_a_path_mode), .slot_b_window(slot_b_window),
  .slot_a_reversed(slot_a_reversed), .slot_b_reversed(slot_b_reversed));

// >>> verification/tb.sv
// Self-checking bench for the slot bank: registers, applied outputs, polarity, windows.
// Drives APB and the slot strobes itself; no far-side model.
`timescale 1ns/100ps
module tb;
  import asc_pkg::*;
  logic        clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, sa = 0;
  logic        a_st = 0, b_st = 0, a_pu = 0, b_pu = 0, pready, pslverr, err;
  logic        buf_mode, a_win, b_win, a_rev, b_rev;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata;
  logic [15:0] rd;
  logic [7:0]  gain;
  logic [1:0]  vref;
  asc_path_t   path;
  int          fails = 0, num_checks = 0;
  logic [7:0]  ix [7] = '{IDX_ORDER_A, IDX_ORDER_B, IDX_WIN_A, IDX_WIN_B, IDX_AMP_A,
                          IDX_ROUTE_A, IDX_CH_GAIN};
  logic [15:0] rv [7] = '{RST_ORDER, RST_ORDER, RST_WIN_A, RST_WIN_B, RST_AMP_A,
                          RST_ROUTE_A, RST_CH_GAIN};
  logic [15:0] rt [4] = '{ROUTE_FULL, ROUTE_TIA_BUF, ROUTE_TIA_DIRECT, 16'h1234};
  asc_path_t   pm [4] = '{PATH_FULL, PATH_TIA_BUF, PATH_TIA_DIRECT, PATH_RESERVED};
  asc_slot_config DUT (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sampling_active(sa), .slot_a_start(a_st), .slot_b_start(b_st),
    .slot_a_pulse(a_pu), .slot_b_pulse(b_pu), .slot_a_ch_gain(gain),
    .slot_a_amp_reference_select(vref), .slot_a_integrator_buffer_mode(buf_mode),
    .slot_a_path_mode(path), .slot_a_window(a_win), .slot_b_window(b_win),
    .slot_a_reversed(a_rev), .slot_b_reversed(b_rev));
  initial begin
    forever #50 clk = ~clk;
  end
  task automatic end_sim;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("unexpected %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Entered just after a rising edge; ends one edge after release
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [15:0] wd);
    int n;
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= {2'b00, idx, 2'b00};
    pwdata  <= {16'h0000, wd};
    wt(1);
    penable <= 1'b1;
    n = 0;
    do begin
      wt(1);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) begin
      fails++;
      end_sim();
    end
    rd = prdata[15:0];
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    wt(1);
  endtask
  // Offset rounds up to whole cycles, then one edge to open
  function automatic int dly(input int off);
    return (off * OFFSET_STEP_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS + 1;
  endfunction
  task automatic meas(input logic b, input int dl, input int len);
    int d;
    int l;
    d = 0;
    l = 0;
    a_st <= !b;
    b_st <= b;
    wt(1);
    a_st <= 1'b0;
    b_st <= 1'b0;
    while ((b ? b_win : a_win) !== 1'b1 && d < 600) begin
      wt(1);
      d++;
    end
    while ((b ? b_win : a_win) === 1'b1 && l < 600) begin
      wt(1);
      l++;
    end
    if (d >= 600 || l >= 600) begin
      fails++;
      end_sim();
    end
    chk("window delay", 16'(dl), 16'(d));
    chk("window length", 16'(len), 16'(l));
  endtask
  initial begin
    wt(20);
    rst_n <= 1'b1;
    wt(1);
    chk("reference", 16'h0003, 16'(vref));
    foreach (ix[i]) begin
      apb(1'b0, ix[i], 16'h0000);
      chk("reset value", rv[i], rd);
    end
    apb(1'b0, 8'h58, 16'h0000);
    chk("unmapped error", 16'h0001, 16'(err));
    for (int v = 0; v < 4; v++) begin
      apb(1'b1, IDX_AMP_A, 16'(16'h1C0A | (v << 4)));
      wt(1);
      chk("reference", 16'(v), 16'(vref));
      chk("shared gain", 16'h00AA, 16'(gain));
    end
    apb(1'b1, IDX_CH_GAIN, 16'h0039);
    apb(1'b1, IDX_AMP_A, 16'h1CD2);
    wt(1);
    chk("channel gains", 16'h00E6, 16'(gain));
    chk("buffer mode", 16'h0001, 16'(buf_mode));
    apb(1'b0, IDX_STATUS, 16'h0000);
    chk("status", 16'h0011, rd);
    foreach (rt[i]) begin
      apb(1'b1, IDX_ROUTE_A, rt[i]);
      apb(1'b0, IDX_ROUTE_A, 16'h0000);
      chk("route readback", rt[i], rd);
      chk("path", 16'(pm[i]), 16'(path));
    end
    sa <= 1'b1;
    apb(1'b1, IDX_AMP_A, 16'h1C3B);
    wt(2);
    chk("frozen gain", 16'h00E6, 16'(gain));
    sa <= 1'b0;
    wt(2);
    chk("applied gain", 16'h00FF, 16'(gain));
    apb(1'b1, IDX_ORDER_A, 16'h0009);
    apb(1'b1, IDX_ORDER_B, 16'h0006);
    wt(1);
    a_st <= 1'b1;
    b_st <= 1'b1;
    wt(1);
    a_st <= 1'b0;
    b_st <= 1'b0;
    a_pu <= 1'b1;
    b_pu <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      wt(1);
      if (i > 0) begin
        chk("slot a polarity", 16'((4'h9 >> ((i - 1) % 4)) & 4'h1), 16'(a_rev));
        chk("slot b polarity", 16'((4'h6 >> ((i - 1) % 4)) & 4'h1), 16'(b_rev));
      end
    end
    a_pu <= 1'b0;
    b_pu <= 1'b0;
    wt(400);
    meas(1'b1, dly(RST_WIN_B[10:0]), RST_WIN_B[15:11] * WIDTH_STEP_CYC);
    meas(1'b0, dly(RST_WIN_A[10:0]), RST_WIN_A[15:11] * WIDTH_STEP_CYC);
    apb(1'b1, IDX_WIN_B, 16'h0801);
    meas(1'b1, dly(1), WIDTH_STEP_CYC);
    end_sim();
  end
endmodule
